// ---- amc_pkg.sv ----
`default_nettype none
package amc_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_FEAT_ERR   = 8'h00;
   localparam logic [7:0] OFS_SECT_CNT   = 8'h04;
   localparam logic [7:0] OFS_SECT_NUM   = 8'h08;
   localparam logic [7:0] OFS_CYL_LOW    = 8'h0C;
   localparam logic [7:0] OFS_CYL_HIGH   = 8'h10;
   localparam logic [7:0] OFS_DEV_HEAD   = 8'h14;
   localparam logic [7:0] OFS_CMD_STAT   = 8'h18;
   localparam logic [7:0] OFS_DEV_CTRL   = 8'h1C;
   localparam logic [7:0] OFS_MODE       = 8'h20;

   // ----------------------------------------------------------------
   // Opcodes, key and subcommands
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_SET_MULT   = 8'hC6;
   localparam logic [7:0] CMD_SLEEP      = 8'hE6;
   localparam logic [7:0] CMD_SLEEP_ALT  = 8'h99;
   localparam logic [7:0] CMD_SMART      = 8'hB0;
   localparam logic [7:0] SMART_KEY_LOW  = 8'h4F;
   localparam logic [7:0] SMART_KEY_HIGH = 8'hC2;
   localparam logic [7:0] SUB_READ_ATTR  = 8'hD0;
   localparam logic [7:0] SUB_READ_THR   = 8'hD1;
   localparam logic [7:0] SUB_AUTOSAVE   = 8'hD2;
   localparam logic [7:0] SUB_SAVE_ATTR  = 8'hD3;
   localparam logic [7:0] SUB_LAST_LOW   = 8'hD6;
   localparam logic [7:0] SUB_ENABLE     = 8'hD8;
   localparam logic [7:0] SUB_DISABLE    = 8'hD9;
   localparam logic [7:0] SUB_LAST_HIGH  = 8'hDB;
   localparam logic [7:0] AUTOSAVE_OFF   = 8'h00;
   localparam logic [7:0] AUTOSAVE_ON    = 8'hF1;
   localparam int         BLOCK_MAX      = 16;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int         ERR_ABT_BIT    = 2;
   localparam int         ST_BSY_BIT     = 7;
   localparam int         ST_RDY_BIT     = 6;
   localparam int         ST_DSC_BIT     = 4;
   localparam int         ST_ERR_BIT     = 0;
   localparam int         CTRL_SRST_BIT  = 2;
   localparam logic [7:0] RST_BYTE       = 8'h00;
   localparam logic [4:0] RST_BLOCK      = 5'h00;

   typedef struct packed {
      logic [7:0] features;
      logic [7:0] sector_count;
      logic [7:0] sector_number;
      logic [7:0] cyl_low;
      logic [7:0] cyl_high;
      logic [7:0] dev_head;
   } amc_tf_t;

   typedef enum logic [3:0] {
      ACT_ABORT, ACT_MULT_ON, ACT_MULT_OFF, ACT_MULT_BAD, ACT_SLEEP,
      ACT_AS_ON, ACT_AS_OFF, ACT_SMART_ON, ACT_SMART_OFF,
      ACT_MEDIA_ATTR, ACT_MEDIA
   } amc_act_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_BUSY  = 3'b001,
      ST_APPLY = 3'b011,
      ST_WAIT  = 3'b111,
      ST_DONE  = 3'b010
   } amc_state_t;

endpackage
`default_nettype wire

// ---- amc_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
module amc_decode (
   input  wire logic [7:0]         command,
   input  wire amc_pkg::amc_tf_t   tf,
   input  wire logic               smart_en,
   output var  amc_pkg::amc_act_t  action
);
   import amc_pkg::*;

   function automatic logic block_ok(input logic [7:0] n);
      block_ok = (n == 8'h00) || ((n <= 8'(BLOCK_MAX)) && ((n & (n - 8'h01)) == 8'h00));
   endfunction

   function automatic logic sub_known(input logic [7:0] s);
      sub_known = ((s >= SUB_READ_ATTR) && (s <= SUB_LAST_LOW))
               || ((s >= SUB_ENABLE) && (s <= SUB_LAST_HIGH));
   endfunction

   always_comb begin
      action = ACT_ABORT;
      case (command)
         CMD_SET_MULT: begin
            if (!block_ok(tf.sector_count)) begin
               action = ACT_MULT_BAD;
            end else if (tf.sector_count == 8'h00) begin
               action = ACT_MULT_OFF;
            end else begin
               action = ACT_MULT_ON;
            end
         end
         CMD_SLEEP, CMD_SLEEP_ALT: begin
            action = ACT_SLEEP;
         end
         CMD_SMART: begin
            if ((tf.cyl_low != SMART_KEY_LOW) || (tf.cyl_high != SMART_KEY_HIGH)
                || !sub_known(tf.features)) begin
               action = ACT_ABORT;
            end else if (!smart_en && (tf.features != SUB_ENABLE)) begin
               action = ACT_ABORT;
            end else begin
               case (tf.features)
                  SUB_ENABLE:    action = ACT_SMART_ON;
                  SUB_DISABLE:   action = ACT_SMART_OFF;
                  SUB_READ_ATTR: action = ACT_MEDIA_ATTR;
                  SUB_AUTOSAVE: begin
                     if (tf.sector_count == AUTOSAVE_OFF) begin
                        action = ACT_AS_OFF;
                     end else if (tf.sector_count == AUTOSAVE_ON) begin
                        action = ACT_AS_ON;
                     end else begin
                        action = ACT_ABORT;
                     end
                  end
                  default:       action = ACT_MEDIA;
               endcase
            end
         end
         default: begin
            action = ACT_ABORT;
         end
      endcase
   end

endmodule
`default_nettype wire

// ---- amc_top.sv ----
// Contract
// - Host writes C6h with block size already in sector count.
// - Valid size enables multiple transfers and records sectors per interrupt.
// - Only sizes 0, 1, 2, 4, 8, 16 accepted; zero disables.
// - Other sizes abort and disable multiple transfers.
// - Opcodes E6h and 99h both enter sleep.
// - Sleep spins down unless already stopped, interface goes inactive.
// - Only software or hardware reset leaves sleep.
// - Recognised subcommands are D0h to D6h and D8h to DBh.
// - D0h first saves attribute values, then returns 512 bytes.
// - D1h fetches thresholds and returns 512 bytes.
// - D2h with count 00h disables autosave.
// - D2h with count F1h enables autosave.
// - D2h with other nonzero count keeps setting and errors.
// - Autosave setting kept in nonvolatile storage.
// - Attribute saves may still happen with autosave off.
// - D9h also turns autosave off.
// - D2h sets BSY, applies change, clears BSY, then raises INTRQ.
// - Error register abort is bit 2; BSY 0 and ERR valid at end.
// - While disabled, every subcommand but enable aborts.
`timescale 1ns/1ps
`default_nettype none
module amc_top (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             intrq,
   input  wire logic        spindle_stopped,
   output logic             spin_down_req,
   output logic             media_req,
   output logic      [7:0]  media_op,
   input  wire logic        media_ack,
   input  wire logic        media_err,
   input  wire logic        nv_autosave,
   input  wire logic        nv_smart_en,
   output logic             nv_store,
   output logic             autosave_en,
   output logic             smart_en,
   output logic             multi_en,
   output logic      [4:0]  block_size,
   output logic             asleep
);
   import amc_pkg::*;

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   amc_tf_t    tf_q,         tf_d;
   logic [31:0] prdata_q,    prdata_d;
   amc_state_t state_q,      state_d;
   amc_act_t   act_q,        act_d;
   amc_act_t   act_dec;
   logic [7:0] err_q,        err_d;
   logic       intrq_q,      intrq_d;
   logic       sleep_q,      sleep_d;
   logic       multi_q,      multi_d;
   logic [4:0] block_q,      block_d;
   logic       as_q,         as_d;
   logic       sm_q,         sm_d;
   logic       load_q,       load_d;
   logic       nv_st_q,      nv_st_d;
   logic       spin_q,       spin_d;
   logic       mreq_q,       mreq_d;
   logic [7:0] mop_q,        mop_d;
   logic       second_q,     second_d;
   logic       stop_m,       stop_s;
   logic       setup;
   logic       access;
   logic       wr;
   logic       mapped;
   logic       busy;
   logic       cmd_go;
   logic       srst;
   logic       stat_rd;
   logic [7:0] status;

   // ----------------------------------------------------------------
   // Spindle pin synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         stop_m <= 1'b0;
         stop_s <= 1'b0;
      end else begin
         stop_m <= spindle_stopped;
         stop_s <= stop_m;
      end
   end

   // ----------------------------------------------------------------
   // APB slave and task file
   // ----------------------------------------------------------------
   assign setup   = psel && !penable;
   assign access  = psel && penable;
   assign wr      = access && pwrite;
   assign busy    = (state_q == ST_BUSY) || (state_q == ST_APPLY) || (state_q == ST_WAIT);
   assign mapped  = (paddr[1:0] == 2'b00) && (paddr <= OFS_MODE);
   assign pready  = 1'b1;
   assign pslverr = access && !mapped;
   assign prdata  = prdata_q;
   assign srst    = wr && (paddr == OFS_DEV_CTRL) && pwdata[CTRL_SRST_BIT];
   assign cmd_go  = wr && (paddr == OFS_CMD_STAT) && !busy && !sleep_q
                    && (state_q == ST_IDLE);
   assign stat_rd = access && !pwrite && (paddr == OFS_CMD_STAT);

   always_comb begin
      status              = RST_BYTE;
      status[ST_BSY_BIT]  = busy;
      status[ST_RDY_BIT]  = !sleep_q;
      status[ST_DSC_BIT]  = !sleep_q;
      status[ST_ERR_BIT]  = err_q[ERR_ABT_BIT];
   end

   always_comb begin
      tf_d     = tf_q;
      prdata_d = prdata_q;
      if (wr && !busy && !sleep_q) begin
         case (paddr)
            OFS_FEAT_ERR: tf_d.features      = pwdata[7:0];
            OFS_SECT_CNT: tf_d.sector_count  = pwdata[7:0];
            OFS_SECT_NUM: tf_d.sector_number = pwdata[7:0];
            OFS_CYL_LOW:  tf_d.cyl_low       = pwdata[7:0];
            OFS_CYL_HIGH: tf_d.cyl_high      = pwdata[7:0];
            OFS_DEV_HEAD: tf_d.dev_head      = pwdata[7:0];
            default:      tf_d               = tf_q;
         endcase
      end
      if (setup && !pwrite) begin
         prdata_d = 32'h0000_0000;
         case (paddr)
            OFS_FEAT_ERR: prdata_d[7:0] = err_q;
            OFS_SECT_CNT: prdata_d[7:0] = tf_q.sector_count;
            OFS_SECT_NUM: prdata_d[7:0] = tf_q.sector_number;
            OFS_CYL_LOW:  prdata_d[7:0] = tf_q.cyl_low;
            OFS_CYL_HIGH: prdata_d[7:0] = tf_q.cyl_high;
            OFS_DEV_HEAD: prdata_d[7:0] = tf_q.dev_head;
            OFS_CMD_STAT: prdata_d[7:0] = status;
            OFS_MODE:     prdata_d[8:0] = {sleep_q, sm_q, as_q, multi_q, block_q};
            default:      prdata_d      = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tf_q     <= '0;
         prdata_q <= 32'h0000_0000;
      end else begin
         tf_q     <= tf_d;
         prdata_q <= prdata_d;
      end
   end

   // ----------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------
   amc_decode u_decode (
      .command  (pwdata[7:0]),
      .tf       (tf_q),
      .smart_en (sm_q),
      .action   (act_dec)
   );

   // ----------------------------------------------------------------
   // Command sequencer
   // ----------------------------------------------------------------
   always_comb begin
      state_d  = state_q;
      act_d    = act_q;
      err_d    = err_q;
      intrq_d  = intrq_q;
      sleep_d  = sleep_q;
      multi_d  = multi_q;
      block_d  = block_q;
      as_d     = as_q;
      sm_d     = sm_q;
      load_d   = 1'b0;
      nv_st_d  = 1'b0;
      spin_d   = 1'b0;
      mreq_d   = 1'b0;
      mop_d    = mop_q;
      second_d = second_q;
      // Status read or new command drops the interrupt
      if (stat_rd || cmd_go) begin
         intrq_d = 1'b0;
      end
      if (load_q) begin
         as_d = nv_autosave;
         sm_d = nv_smart_en;
      end
      case (state_q)
         ST_IDLE: begin
            if (cmd_go) begin
               act_d    = act_dec;
               err_d    = RST_BYTE;
               second_d = 1'b0;
               state_d  = ST_BUSY;
            end
         end
         ST_BUSY: begin
            state_d = ST_APPLY;
         end
         ST_APPLY: begin
            state_d = ST_DONE;
            case (act_q)
               ACT_MULT_ON: begin
                  multi_d = 1'b1;
                  block_d = tf_q.sector_count[4:0];
               end
               ACT_MULT_OFF: begin
                  multi_d = 1'b0;
                  block_d = RST_BLOCK;
               end
               ACT_MULT_BAD: begin
                  multi_d = 1'b0;
                  block_d = RST_BLOCK;
                  err_d[ERR_ABT_BIT] = 1'b1;
               end
               ACT_SLEEP: begin
                  if (!stop_s) begin
                     spin_d  = 1'b1;
                     state_d = ST_WAIT;
                  end
               end
               ACT_AS_ON: begin
                  as_d    = 1'b1;
                  nv_st_d = 1'b1;
               end
               ACT_AS_OFF: begin
                  as_d    = 1'b0;
                  nv_st_d = 1'b1;
               end
               ACT_SMART_ON: begin
                  sm_d    = 1'b1;
                  nv_st_d = 1'b1;
               end
               ACT_SMART_OFF: begin
                  sm_d    = 1'b0;
                  as_d    = 1'b0;
                  nv_st_d = 1'b1;
               end
               ACT_MEDIA_ATTR: begin
                  mop_d   = SUB_SAVE_ATTR;
                  mreq_d  = 1'b1;
                  state_d = ST_WAIT;
               end
               ACT_MEDIA: begin
                  mop_d   = tf_q.features;
                  mreq_d  = 1'b1;
                  state_d = ST_WAIT;
               end
               default: begin
                  err_d[ERR_ABT_BIT] = 1'b1;
               end
            endcase
         end
         ST_WAIT: begin
            if (act_q == ACT_SLEEP) begin
               if (stop_s) begin
                  state_d = ST_DONE;
               end
            end else if (media_ack) begin
               if (media_err) begin
                  err_d[ERR_ABT_BIT] = 1'b1;
                  state_d = ST_DONE;
               end else if ((act_q == ACT_MEDIA_ATTR) && !second_q) begin
                  second_d = 1'b1;
                  mop_d    = SUB_READ_ATTR;
                  mreq_d   = 1'b1;
               end else begin
                  state_d = ST_DONE;
               end
            end
         end
         ST_DONE: begin
            intrq_d = 1'b1;
            state_d = ST_IDLE;
            if (act_q == ACT_SLEEP) begin
               sleep_d = 1'b1;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      if (srst) begin
         state_d = ST_IDLE;
         sleep_d = 1'b0;
         err_d   = RST_BYTE;
         intrq_d = 1'b0;
         mreq_d  = 1'b0;
         spin_d  = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_q  <= ST_IDLE;
         act_q    <= ACT_ABORT;
         err_q    <= RST_BYTE;
         intrq_q  <= 1'b0;
         sleep_q  <= 1'b0;
         multi_q  <= 1'b0;
         block_q  <= RST_BLOCK;
         as_q     <= 1'b0;
         sm_q     <= 1'b0;
         load_q   <= 1'b1;
         nv_st_q  <= 1'b0;
         spin_q   <= 1'b0;
         mreq_q   <= 1'b0;
         mop_q    <= RST_BYTE;
         second_q <= 1'b0;
      end else begin
         state_q  <= state_d;
         act_q    <= act_d;
         err_q    <= err_d;
         intrq_q  <= intrq_d;
         sleep_q  <= sleep_d;
         multi_q  <= multi_d;
         block_q  <= block_d;
         as_q     <= as_d;
         sm_q     <= sm_d;
         load_q   <= load_d;
         nv_st_q  <= nv_st_d;
         spin_q   <= spin_d;
         mreq_q   <= mreq_d;
         mop_q    <= mop_d;
         second_q <= second_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign intrq         = intrq_q;
   assign spin_down_req = spin_q;
   assign media_req     = mreq_q;
   assign media_op      = mop_q;
   assign nv_store      = nv_st_q;
   assign autosave_en   = as_q;
   assign smart_en      = sm_q;
   assign multi_en      = multi_q;
   assign block_size    = block_q;
   assign asleep        = sleep_q;

endmodule
`default_nettype wire

// ---- amc_chk_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module amc_chk (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        intrq,
   input wire logic        spindle_stopped,
   input wire logic        spin_down_req,
   input wire logic        media_req,
   input wire logic [7:0]  media_op,
   input wire logic        media_ack,
   input wire logic        media_err,
   input wire logic        nv_store,
   input wire logic        autosave_en,
   input wire logic        smart_en,
   input wire logic        multi_en,
   input wire logic [4:0]  block_size,
   input wire logic        asleep
);
   import amc_pkg::*;
   logic soft_rst;
   assign soft_rst = psel && penable && pwrite && paddr == OFS_DEV_CTRL && pwdata[CTRL_SRST_BIT];
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // ----
   // Sequences
   // ----
   sequence s_save_acked;
      $past(media_ack) && !$past(media_err);
   endsequence
   sequence s_long_stopped;
      spindle_stopped [*4];
   endsequence
   // ----
   // Properties
   // ----
   property p_block_legal;
      block_size inside {5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10};
   endproperty
   a_block_legal: assert property (p_block_legal) else $error("illegal block size");
   property p_multi_tracks;
      multi_en == (block_size != 5'h00);
   endproperty
   a_multi_tracks: assert property (p_multi_tracks) else $error("multi enable wrong");
   property p_off_clears_as;
      $fell(smart_en) |-> !autosave_en;
   endproperty
   a_off_clears_as: assert property (p_off_clears_as) else $error("autosave kept");
   property p_mode_stored;
      ($changed(autosave_en) || $changed(smart_en)) && !$past(reset, 2) |-> nv_store;
   endproperty
   a_mode_stored: assert property (p_mode_stored) else $error("mode not stored");
   property p_wake_by_reset;
      $fell(asleep) |-> $past(soft_rst) || $past(soft_rst, 2);
   endproperty
   a_wake_by_reset: assert property (p_wake_by_reset) else $error("left sleep");
   property p_no_spin;
      s_long_stopped |=> !spin_down_req;
   endproperty
   a_no_spin: assert property (p_no_spin) else $error("spin down while stopped");
   property p_intrq_after;
      nv_store |-> ##[1:3] intrq;
   endproperty
   a_intrq_after: assert property (p_intrq_after) else $error("no interrupt");
   property p_save_first;
      media_req && media_op == SUB_READ_ATTR |-> s_save_acked;
   endproperty
   a_save_first: assert property (p_save_first) else $error("read before save");
endmodule
bind amc_top amc_chk u_chk (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .intrq(intrq),
   .spindle_stopped(spindle_stopped), .spin_down_req(spin_down_req), .media_req(media_req),
   .media_op(media_op), .media_ack(media_ack), .media_err(media_err), .nv_store(nv_store),
   .autosave_en(autosave_en), .smart_en(smart_en), .multi_en(multi_en),
   .block_size(block_size), .asleep(asleep));
`default_nettype wire

// ---- amc_mech_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module amc_mech_model (
   input wire logic  clk,
   input wire logic  media_req,
   input wire logic  spin_down_req,
   input wire logic  nv_store,
   input wire logic  autosave_en,
   input wire logic  smart_en,
   input wire logic  fail_next,
   output logic      media_ack,
   output logic      media_err,
   output logic      spindle_stopped,
   output logic      nv_autosave,
   output logic      nv_smart_en
);
   // Mechanics and storage survive reset, as a drive would
   logic [3:0] cnt_q = 4'h0, cnt_d;
   logic [2:0] spin_q = 3'h0, spin_d;
   logic       slow_q = 1'b0, ack_q = 1'b0, fail_q = 1'b0, stop_q = 1'b0;
   logic       nva_q = 1'b0, nvs_q = 1'b1, stop_d, nva_d, nvs_d;
   always_comb begin
      cnt_d = media_req ? (slow_q ? 4'h6 : 4'h2) : (cnt_q != 4'h0 ? cnt_q - 4'h1 : 4'h0);
      spin_d = spin_down_req ? 3'h4 : (spin_q != 3'h0 ? spin_q - 3'h1 : 3'h0);
      stop_d = stop_q || spin_q == 3'h1;
      nva_d = nv_store ? autosave_en : nva_q;
      nvs_d = nv_store ? smart_en : nvs_q;
   end
   always_ff @(posedge clk) begin
      cnt_q <= cnt_d;
      slow_q <= slow_q ^ media_req;
      ack_q <= cnt_q == 4'h1;
      fail_q <= fail_next;
      spin_q <= spin_d;
      stop_q <= stop_d;
      nva_q <= nva_d;
      nvs_q <= nvs_d;
   end
   assign media_ack = ack_q;
   assign media_err = ack_q ? fail_q : slow_q;
   assign spindle_stopped = stop_q;
   assign nv_autosave = nva_q;
   assign nv_smart_en = nvs_q;
endmodule
`default_nettype wire

// ---- tb_ata_multiple_sleep_smart_cmds.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_ata_multiple_sleep_smart_cmds;
   import amc_pkg::*;
   logic        clk = 1'b0, reset, psel, penable, pwrite, fail_next, se;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, intrq, stopped, spin_req, mreq, mack, merr;
   logic        nv_as, nv_sm, nv_store, as_en, sm_en, multi_en, asleep;
   logic [7:0]  mop;
   logic [4:0]  block_size;
   logic [7:0]  sizes [9] = '{8'h04, 8'h03, 8'h10, 8'h00, 8'h01, 8'h02, 8'h08, 8'h20, 8'hFF};
   int          n_errors = 0, comparisons = 0, cycles = 0, spins = 0;
   amc_top dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .intrq(intrq), .spindle_stopped(stopped), .spin_down_req(spin_req), .media_req(mreq),
      .media_op(mop), .media_ack(mack), .media_err(merr), .nv_autosave(nv_as),
      .nv_smart_en(nv_sm), .nv_store(nv_store), .autosave_en(as_en), .smart_en(sm_en),
      .multi_en(multi_en), .block_size(block_size), .asleep(asleep));
   amc_mech_model u_mech (.clk(clk), .media_req(mreq), .spin_down_req(spin_req),
      .nv_store(nv_store), .autosave_en(as_en), .smart_en(sm_en), .fail_next(fail_next),
      .media_ack(mack), .media_err(merr), .spindle_stopped(stopped), .nv_autosave(nv_as),
      .nv_smart_en(nv_sm));
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (spin_req === 1'b1)
         spins++;
      if (cycles == 20000) begin
         n_errors++;
         complete_run();
      end
   end
   // ----
   // Tasks
   // ----
   task automatic complete_run;
      $display("Comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic mode(input logic [31:0] exp);
      xfer(1'b0, OFS_MODE, 32'h0000_0000);
      chk("mode", exp, rd);
   endtask
   task automatic cmd(input logic [7:0] op, input logic err);
      int k;
      xfer(1'b1, OFS_CMD_STAT, 32'(op));
      k = 0;
      while (intrq !== 1'b1 && k < 400) begin
         @(posedge clk);
         k++;
      end
      chk("intrq", 32'h0000_0001, 32'(intrq));
      xfer(1'b0, OFS_CMD_STAT, 32'h0000_0000);
      chk("busy", 32'h0000_0000, 32'(rd[ST_BSY_BIT]));
      chk("status err", 32'(err), 32'(rd[ST_ERR_BIT]));
      xfer(1'b0, OFS_FEAT_ERR, 32'h0000_0000);
      chk("error reg", err ? 32'h0000_0004 : 32'h0000_0000, rd);
   endtask
   task automatic sm(input logic [7:0] feat, input logic [7:0] cnt, input logic err);
      xfer(1'b1, OFS_FEAT_ERR, 32'(feat));
      xfer(1'b1, OFS_SECT_CNT, 32'(cnt));
      cmd(CMD_SMART, err);
   endtask
   // ----
   // Main sequence
   // ----
   initial begin
      logic       ok;
      logic [7:0] c;
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      fail_next = 1'b0;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      mode(32'h0000_0080);
      xfer(1'b0, 8'h24, 32'h0000_0000);
      chk("unmapped slverr", 32'h0000_0001, 32'(se));
      foreach (sizes[i]) begin
         ok = sizes[i] inside {8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10};
         xfer(1'b1, OFS_SECT_CNT, 32'(sizes[i]));
         cmd(CMD_SET_MULT, !ok);
         mode(32'h0000_0080 | (ok && sizes[i] != 8'h00 ? 32'h0000_0020 : 32'h0000_0000)
              | (ok ? 32'(sizes[i][4:0]) : 32'h0000_0000));
      end
      xfer(1'b1, OFS_CYL_LOW, 32'(SMART_KEY_LOW));
      xfer(1'b1, OFS_CYL_HIGH, 32'(SMART_KEY_HIGH));
      sm(SUB_AUTOSAVE, AUTOSAVE_ON, 1'b0);
      mode(32'h0000_00C0);
      sm(SUB_AUTOSAVE, 8'h05, 1'b1);
      mode(32'h0000_00C0);
      sm(SUB_AUTOSAVE, AUTOSAVE_OFF, 1'b0);
      mode(32'h0000_0080);
      sm(SUB_AUTOSAVE, AUTOSAVE_ON, 1'b0);
      for (c = 8'hCF; c != 8'hDD; c++) begin
         if (c != SUB_ENABLE && c != SUB_DISABLE)
            sm(c, 8'h01, c < 8'hD0 || c == 8'hD7 || c == SUB_AUTOSAVE || c > 8'hDB);
      end
      fail_next <= 1'b1;
      sm(SUB_READ_THR, 8'h01, 1'b1);
      fail_next <= 1'b0;
      chk("media op", 32'(SUB_READ_THR), 32'(mop));
      xfer(1'b1, OFS_CYL_HIGH, 32'h0000_00C3);
      sm(SUB_SAVE_ATTR, 8'h01, 1'b1);
      xfer(1'b1, OFS_CYL_HIGH, 32'(SMART_KEY_HIGH));
      sm(SUB_DISABLE, 8'h00, 1'b0);
      mode(32'h0000_0000);
      chk("stored monitor", 32'h0000_0000, 32'(nv_sm));
      sm(SUB_READ_ATTR, 8'h00, 1'b1);
      sm(SUB_DISABLE, 8'h00, 1'b1);
      sm(SUB_AUTOSAVE, AUTOSAVE_ON, 1'b1);
      sm(SUB_ENABLE, 8'h00, 1'b0);
      sm(SUB_AUTOSAVE, AUTOSAVE_ON, 1'b0);
      cmd(CMD_SLEEP, 1'b0);
      mode(32'h0000_01C0);
      chk("spin downs", 32'h0000_0001, 32'(spins));
      xfer(1'b1, OFS_CMD_STAT, 32'(CMD_SLEEP_ALT));
      mode(32'h0000_01C0);
      xfer(1'b1, OFS_DEV_CTRL, 32'h0000_0004);
      mode(32'h0000_00C0);
      cmd(CMD_SLEEP_ALT, 1'b0);
      chk("spin downs", 32'h0000_0001, 32'(spins));
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      mode(32'h0000_00C0);
      complete_run();
   end
endmodule
`default_nettype wire
